// File: sfr_bank_defines.svh
`ifndef SFR_BANK_DEFINES_SVH
`define SFR_BANK_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets (direct address space)
// ----------------------------------------------------------------
`define STACK_POINTER_OFFS       8'h81
`define TIMER_CONTROL_OFFS       8'h88
`define TIMER_MODE_OFFS          8'h89
`define TIMER_ZERO_LOW_OFFS      8'h8a
`define TIMER_ONE_LOW_OFFS       8'h8b
`define TIMER_ZERO_HIGH_OFFS     8'h8c
`define TIMER_ONE_HIGH_OFFS      8'h8d
`define OSC_CALIBRATION_OFFS     8'h96
`define SERIAL_CONTROL_OFFS      8'h98
`define SERIAL_DATA_OFFS         8'h99
`define WATCHDOG_CONTROL_OFFS    8'ha7
`define SERIAL_NODE_ADDR_OFFS    8'ha9
`define SERIAL_ADDR_MASK_OFFS    8'hb9
`define SERIAL_EXT_STATUS_OFFS   8'hba
`define WATCHDOG_RELOAD_OFFS     8'hc1
`define WATCHDOG_SERVICE1_OFFS   8'hc2
`define WATCHDOG_SERVICE2_OFFS   8'hc3
`define STATUS_WORD_OFFS         8'hd0
`define RTC_CONTROL_OFFS         8'hd1
`define RTC_COUNT_HIGH_OFFS      8'hd2
`define RTC_COUNT_LOW_OFFS       8'hd3
`define RESET_CAUSE_OFFS         8'hdf
`define PORT0_INBUF_DIS_OFFS     8'hf6
`define BAUD_GEN_CONTROL_OFFS    8'hec
`define BAUD_DIVISOR_LOW_OFFS    8'hed
`define BAUD_DIVISOR_HIGH_OFFS   8'hee

// ----------------------------------------------------------------
// reset values and implemented-bit masks
// ----------------------------------------------------------------
`define STACK_POINTER_RST        8'h07
`define WATCHDOG_RELOAD_RST      8'hff
`define RTC_CONTROL_RST          8'h60
`define ZERO_RST                 8'h00
`define WATCHDOG_CONTROL_RST     8'he5
`define RESET_CAUSE_POR          8'h30
`define FULL_MASK                8'hff
`define TIMER_CONTROL_MASK       8'hf0
`define TIMER_MODE_MASK          8'h33
`define PORT0_INBUF_MASK         8'h3e
`define RTC_CONTROL_MASK         8'he3
`define WATCHDOG_CONTROL_MASK    8'he7
`define RESET_CAUSE_MASK         8'h3f
`define BAUD_GEN_CONTROL_MASK    8'h01

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define WATCHDOG_TIMEOUT_BIT     1
`define BROWNOUT_FLAG_BIT        5
`define POWER_ON_FLAG_BIT        4
`define CAUSE_BREAK_BIT          3
`define CAUSE_WATCHDOG_BIT       2
`define CAUSE_SOFTWARE_BIT       1
`define CAUSE_EXTERNAL_BIT       0
`define CLOCK_OUTPUT_ENABLE_BIT  6
`define RC_OSC_SELECT_BIT        7
`define BAUD_GEN_ENABLE_BIT      0

// ----------------------------------------------------------------
// memory spaces
// ----------------------------------------------------------------
`define DATA_RAM_BYTES           128
`define CODE_ONCHIP_BYTES        1024
`define CODE_EMPTY_VALUE         8'hff

`endif

// File: sfr_bank_pkg.sv
package sfr_bank_pkg;
  // which space a byte access lands in
  typedef enum logic [1:0] {SPACE_NONE, SPACE_RAM, SPACE_SFR} space_t;
  typedef logic [7:0] byte_t;
endpackage

// File: sfr_bank.sv
`include "sfr_bank_defines.svh"

// Functional notes
// - unimplemented sfr bits carry no value and read back as an undefined level (zero here).
// - the baud divisor registers may only be written while the baud generator is disabled.
// - power-on leaves only the power-on and brownout flags set, so the cause reads xx110000.
// - after reset the watchdog control reads 111001x1 (prescale, run and clock bits at one).
// - a watchdog reset sets the timeout flag, power-on clears it, other resets keep it.
// - power-on loads the factory calibration into the trim register and nothing else does.
// - rtc control, both rtc counts, trim and watchdog control respond to power-on reset only.
// - status word, serial control and timer control are bit addressable from d0, 98 and 88.
// - 128 bytes of data ram at 00-7f are reached by direct and indirect addressing.
// - sfrs are reached by direct and bit addressing only, never by indirect accesses.
// - the code space spans 64 kB of addresses with 1 kB implemented on chip.
// - trim bit 6 drives half the cpu clock onto the clock pin, bit 7 selects the rc clock.
module sfr_bank
  import sfr_bank_pkg::*;
#(
  parameter int RAM_BYTES   = `DATA_RAM_BYTES,
  parameter int CODE_ONCHIP = `CODE_ONCHIP_BYTES
) (
  input  wire logic        clk_sys_in,
  input  wire logic        reset_n_in,
  input  wire logic        rst_external_in,
  input  wire logic        rst_watchdog_in,
  input  wire logic        rst_software_in,
  input  wire logic        rst_break_in,
  input  wire logic        rst_brownout_in,
  input  wire logic [5:0]  trim_factory_in,
  input  wire logic [7:0]  dir_addr_in,
  input  wire logic        dir_wr_in,
  input  wire logic        dir_rd_in,
  input  wire logic [7:0]  dir_wdata_in,
  input  wire logic [7:0]  ind_addr_in,
  input  wire logic        ind_wr_in,
  input  wire logic        ind_rd_in,
  input  wire logic [7:0]  ind_wdata_in,
  input  wire logic [7:0]  bit_addr_in,
  input  wire logic        bit_wr_in,
  input  wire logic        bit_rd_in,
  input  wire logic        bit_wdata_in,
  input  wire logic [15:0] code_addr_in,
  input  wire logic        code_rd_in,
  input  wire logic [7:0]  code_mem_data_in,
  output logic      [7:0]  dir_rdata_out,
  output logic      [7:0]  ind_rdata_out,
  output logic             bit_rdata_out,
  output logic      [9:0]  code_mem_addr_out,
  output logic      [7:0]  code_rdata_out,
  output logic             code_valid_out,
  output logic             clock_output_pin_out,
  output logic             rc_oscillator_select_out,
  output logic             watchdog_service_first_out,
  output logic             watchdog_service_second_out
);

  // ----------------------------------------------------------------
  // generic register table
  // ----------------------------------------------------------------
  localparam int NREG     = 21;
  localparam int BAUD_IDX = 15;
  localparam int RAM_AW   = $clog2(RAM_BYTES);
  localparam byte_t OFFS [NREG] = '{`STACK_POINTER_OFFS, `TIMER_CONTROL_OFFS, `TIMER_MODE_OFFS,
    `TIMER_ZERO_LOW_OFFS, `TIMER_ONE_LOW_OFFS, `TIMER_ZERO_HIGH_OFFS, `TIMER_ONE_HIGH_OFFS,
    `SERIAL_CONTROL_OFFS, `SERIAL_DATA_OFFS, `SERIAL_NODE_ADDR_OFFS, `SERIAL_ADDR_MASK_OFFS,
    `SERIAL_EXT_STATUS_OFFS, `WATCHDOG_RELOAD_OFFS, `STATUS_WORD_OFFS, `PORT0_INBUF_DIS_OFFS,
    `BAUD_GEN_CONTROL_OFFS, `BAUD_DIVISOR_LOW_OFFS, `BAUD_DIVISOR_HIGH_OFFS,
    `RTC_CONTROL_OFFS, `RTC_COUNT_HIGH_OFFS, `RTC_COUNT_LOW_OFFS};
  localparam byte_t RSTV [NREG] = '{`STACK_POINTER_RST, `ZERO_RST, `ZERO_RST, `ZERO_RST,
    `ZERO_RST, `ZERO_RST, `ZERO_RST, `ZERO_RST, `ZERO_RST, `ZERO_RST, `ZERO_RST, `ZERO_RST,
    `WATCHDOG_RELOAD_RST, `ZERO_RST, `ZERO_RST, `ZERO_RST, `ZERO_RST, `ZERO_RST,
    `RTC_CONTROL_RST, `ZERO_RST, `ZERO_RST};
  localparam byte_t MASK [NREG] = '{`FULL_MASK, `TIMER_CONTROL_MASK, `TIMER_MODE_MASK,
    `FULL_MASK, `FULL_MASK, `FULL_MASK, `FULL_MASK, `FULL_MASK, `FULL_MASK, `FULL_MASK,
    `FULL_MASK, `FULL_MASK, `FULL_MASK, `FULL_MASK, `PORT0_INBUF_MASK,
    `BAUD_GEN_CONTROL_MASK, `FULL_MASK, `FULL_MASK, `RTC_CONTROL_MASK, `FULL_MASK,
    `FULL_MASK};
  // per-entry flags, bit n belongs to entry n
  localparam logic [NREG-1:0] POR_ONLY = 21'h1c_0000;
  localparam logic [NREG-1:0] BIT_ADDR = 21'h00_2082;
  localparam logic [NREG-1:0] LOCKABLE = 21'h03_0000;

  logic [7:0] reg_ff  [NREG];
  logic [7:0] nxt_reg [NREG];
  logic [7:0] ram_ff  [RAM_BYTES];
  logic [7:0] nxt_ram [RAM_BYTES];
  logic [7:0] trim_ff, nxt_trim, watchdog_control_ff, nxt_watchdog_control, cause_ff, nxt_cause;
  logic       trim_load_ff;
  logic [7:0] dir_val, ind_val;
  logic       bit_val;
  logic [7:0] bit_byte;
  logic       any_rst, dir_sfr_wr;
  space_t     dir_space, ind_space;

  // secondary reset sources arrive as one-cycle pulses on the system clock
  assign any_rst    = rst_external_in | rst_watchdog_in | rst_software_in
                    | rst_break_in | rst_brownout_in;
  assign dir_space  = dir_addr_in[7] ? SPACE_SFR : SPACE_RAM;
  // indirect accesses above the ram never land in the sfr space
  assign ind_space  = ind_addr_in[7] ? SPACE_NONE : SPACE_RAM;
  assign dir_sfr_wr = dir_wr_in && (dir_space == SPACE_SFR);
  assign bit_byte   = {bit_addr_in[7:3], 3'b000};

  // ----------------------------------------------------------------
  // generic sfrs and data ram
  // ----------------------------------------------------------------
  // reset beats software write, direct byte write beats bit write
  for (genvar g = 0; g < NREG; g++) begin : gen_reg
    always_comb begin
      nxt_reg[g] = reg_ff[g];
      if (any_rst && !POR_ONLY[g]) begin
        nxt_reg[g] = RSTV[g];
      end else if (dir_sfr_wr && dir_addr_in == OFFS[g]) begin
        // divisor writes are dropped while the generator runs
        if (!(LOCKABLE[g] && reg_ff[BAUD_IDX][`BAUD_GEN_ENABLE_BIT])) begin
          nxt_reg[g] = dir_wdata_in & MASK[g];
        end
      end else if (bit_wr_in && BIT_ADDR[g] && bit_byte == OFFS[g]) begin
        nxt_reg[g][bit_addr_in[2:0]] = bit_wdata_in & MASK[g][bit_addr_in[2:0]];
      end
    end
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) reg_ff[g] <= RSTV[g];
      else reg_ff[g] <= nxt_reg[g];
    end
  end

  // data ram: direct write wins over an indirect write to the same byte
  for (genvar r = 0; r < RAM_BYTES; r++) begin : gen_ram
    always_comb begin
      nxt_ram[r] = ram_ff[r];
      if (dir_wr_in && dir_space == SPACE_RAM && dir_addr_in[RAM_AW-1:0] == RAM_AW'(r)) begin
        nxt_ram[r] = dir_wdata_in;
      end else if (ind_wr_in && ind_space == SPACE_RAM
                   && ind_addr_in[RAM_AW-1:0] == RAM_AW'(r)) begin
        nxt_ram[r] = ind_wdata_in;
      end
    end
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) ram_ff[r] <= `ZERO_RST;
      else ram_ff[r] <= nxt_ram[r];
    end
  end

  // ----------------------------------------------------------------
  // power-on-only registers: trim, watchdog control, reset cause
  // ----------------------------------------------------------------
  // the strap is caught on the first edge after release, never under reset
  always_comb begin
    nxt_trim  = trim_ff;
    nxt_watchdog_control = watchdog_control_ff;
    nxt_cause = cause_ff;
    if (trim_load_ff) begin
      nxt_trim = {2'b00, trim_factory_in};
    end else if (dir_sfr_wr && dir_addr_in == `OSC_CALIBRATION_OFFS) begin
      nxt_trim = dir_wdata_in;
    end
    if (dir_sfr_wr && dir_addr_in == `WATCHDOG_CONTROL_OFFS) begin
      nxt_watchdog_control = dir_wdata_in & `WATCHDOG_CONTROL_MASK;
    end
    // a watchdog reset wins over a software clear of the flag
    if (rst_watchdog_in) nxt_watchdog_control[`WATCHDOG_TIMEOUT_BIT] = 1'b1;
    if (dir_sfr_wr && dir_addr_in == `RESET_CAUSE_OFFS) begin
      nxt_cause = dir_wdata_in & `RESET_CAUSE_MASK;
    end
    // hardware sets beat a software write in the same cycle
    nxt_cause[`BROWNOUT_FLAG_BIT]  = nxt_cause[`BROWNOUT_FLAG_BIT] | rst_brownout_in;
    nxt_cause[`CAUSE_BREAK_BIT]    = nxt_cause[`CAUSE_BREAK_BIT] | rst_break_in;
    nxt_cause[`CAUSE_WATCHDOG_BIT] = nxt_cause[`CAUSE_WATCHDOG_BIT] | rst_watchdog_in;
    nxt_cause[`CAUSE_SOFTWARE_BIT] = nxt_cause[`CAUSE_SOFTWARE_BIT] | rst_software_in;
    nxt_cause[`CAUSE_EXTERNAL_BIT] = nxt_cause[`CAUSE_EXTERNAL_BIT] | rst_external_in;
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      trim_ff      <= `ZERO_RST;
      trim_load_ff <= 1'b1;
      watchdog_control_ff     <= `WATCHDOG_CONTROL_RST;
      cause_ff     <= `RESET_CAUSE_POR;
    end else begin
      trim_ff      <= nxt_trim;
      trim_load_ff <= 1'b0;
      watchdog_control_ff     <= nxt_watchdog_control;
      cause_ff     <= nxt_cause;
    end
  end

  // ----------------------------------------------------------------
  // read multiplexers
  // ----------------------------------------------------------------
  // write-only service registers and unmapped addresses read as zero
  always_comb begin
    dir_val = `ZERO_RST;
    bit_val = 1'b0;
    if (dir_space == SPACE_RAM) begin
      dir_val = ram_ff[dir_addr_in[RAM_AW-1:0]];
    end else if (dir_addr_in == `OSC_CALIBRATION_OFFS) begin
      dir_val = trim_ff;
    end else if (dir_addr_in == `WATCHDOG_CONTROL_OFFS) begin
      dir_val = watchdog_control_ff;
    end else if (dir_addr_in == `RESET_CAUSE_OFFS) begin
      dir_val = cause_ff;
    end else begin
      for (int i = 0; i < NREG; i++) begin
        if (dir_addr_in == OFFS[i]) dir_val = reg_ff[i];
      end
    end
    ind_val = (ind_space == SPACE_RAM) ? ram_ff[ind_addr_in[RAM_AW-1:0]] : `ZERO_RST;
    for (int j = 0; j < NREG; j++) begin
      if (BIT_ADDR[j] && bit_byte == OFFS[j]) bit_val = reg_ff[j][bit_addr_in[2:0]];
    end
  end

  // ----------------------------------------------------------------
  // registered outputs: read data, code port, clock pin, service strobes
  // ----------------------------------------------------------------
  logic [7:0] dir_rdata_ff, nxt_dir_rdata, ind_rdata_ff, nxt_ind_rdata;
  logic [7:0] code_rdata_ff, nxt_code_rdata;
  logic [9:0] code_addr_ff, nxt_code_addr;
  logic       bit_rdata_ff, nxt_bit_rdata, code_pend_ff, nxt_code_pend;
  logic       code_in_ff, nxt_code_in, code_valid_ff, nxt_code_valid;
  logic       clock_output_pin_ff, nxt_clock_output_pin, rcsel_ff, nxt_rcsel, svc1_ff, nxt_svc1, svc2_ff, nxt_svc2;

  // code beyond the on-chip array reads as erased; the fetch takes two edges
  always_comb begin
    nxt_dir_rdata  = dir_rd_in ? dir_val : dir_rdata_ff;
    nxt_ind_rdata  = ind_rd_in ? ind_val : ind_rdata_ff;
    nxt_bit_rdata  = bit_rd_in ? bit_val : bit_rdata_ff;
    nxt_code_addr  = code_rd_in ? code_addr_in[9:0] : code_addr_ff;
    nxt_code_in    = code_rd_in ? (32'(code_addr_in) < CODE_ONCHIP) : code_in_ff;
    nxt_code_pend  = code_rd_in;
    nxt_code_valid = code_pend_ff;
    nxt_code_rdata = code_rdata_ff;
    if (code_pend_ff) nxt_code_rdata = code_in_ff ? code_mem_data_in : `CODE_EMPTY_VALUE;
    // pin toggles every cycle, giving half the cpu clock while enabled
    nxt_clock_output_pin = trim_ff[`CLOCK_OUTPUT_ENABLE_BIT] ? ~clock_output_pin_ff : 1'b0;
    nxt_rcsel  = trim_ff[`RC_OSC_SELECT_BIT];
    nxt_svc1   = dir_sfr_wr && dir_addr_in == `WATCHDOG_SERVICE1_OFFS;
    nxt_svc2   = dir_sfr_wr && dir_addr_in == `WATCHDOG_SERVICE2_OFFS;
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dir_rdata_ff  <= `ZERO_RST;
      ind_rdata_ff  <= `ZERO_RST;
      bit_rdata_ff  <= 1'b0;
      code_addr_ff  <= 10'h000;
      code_in_ff    <= 1'b0;
      code_pend_ff  <= 1'b0;
      code_valid_ff <= 1'b0;
      code_rdata_ff <= `ZERO_RST;
      clock_output_pin_ff     <= 1'b0;
      rcsel_ff      <= 1'b0;
      svc1_ff       <= 1'b0;
      svc2_ff       <= 1'b0;
    end else begin
      dir_rdata_ff  <= nxt_dir_rdata;
      ind_rdata_ff  <= nxt_ind_rdata;
      bit_rdata_ff  <= nxt_bit_rdata;
      code_addr_ff  <= nxt_code_addr;
      code_in_ff    <= nxt_code_in;
      code_pend_ff  <= nxt_code_pend;
      code_valid_ff <= nxt_code_valid;
      code_rdata_ff <= nxt_code_rdata;
      clock_output_pin_ff     <= nxt_clock_output_pin;
      rcsel_ff      <= nxt_rcsel;
      svc1_ff       <= nxt_svc1;
      svc2_ff       <= nxt_svc2;
    end
  end

  assign dir_rdata_out               = dir_rdata_ff;
  assign ind_rdata_out               = ind_rdata_ff;
  assign bit_rdata_out               = bit_rdata_ff;
  assign code_mem_addr_out           = code_addr_ff;
  assign code_rdata_out              = code_rdata_ff;
  assign code_valid_out              = code_valid_ff;
  assign clock_output_pin_out        = clock_output_pin_ff;
  assign rc_oscillator_select_out    = rcsel_ff;
  assign watchdog_service_first_out  = svc1_ff;
  assign watchdog_service_second_out = svc2_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence code_far_s;
    code_rd_in && code_addr_in >= 16'(CODE_ONCHIP);
  endsequence
  sequence code_done_s;
    ##2 code_valid_out && code_rdata_out == `CODE_EMPTY_VALUE;
  endsequence

  stack_reset_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    any_rst |=> reg_ff[0] == `STACK_POINTER_RST)
    else $error("stack pointer missed its reset value");
  rtc_hold_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (any_rst && !dir_wr_in) |=> $stable(reg_ff[18]) && $stable(reg_ff[19])
      && $stable(reg_ff[20]))
    else $error("rtc register moved on a non power-on reset");
  cause_por_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (trim_load_ff && !any_rst) |-> cause_ff == `RESET_CAUSE_POR)
    else $error("reset cause wrong after power-on");
  wdt_flag_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    rst_watchdog_in |=> watchdog_control_ff[`WATCHDOG_TIMEOUT_BIT])
    else $error("watchdog reset did not set timeout flag");
  wdt_keep_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (any_rst && !rst_watchdog_in && !dir_wr_in) |=> $stable(watchdog_control_ff))
    else $error("watchdog control changed on another reset");
  watchdog_control_init_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    trim_load_ff |-> watchdog_control_ff == `WATCHDOG_CONTROL_RST)
    else $error("watchdog control wrong after power-on");
  trim_load_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    trim_load_ff |=> trim_ff == {2'b00, $past(trim_factory_in)})
    else $error("trim not loaded with factory value");
  trim_keep_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (any_rst && !trim_load_ff && !dir_wr_in) |=> $stable(trim_ff))
    else $error("trim reinitialised by a non power-on reset");
  clock_pin_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    $past(trim_ff[`CLOCK_OUTPUT_ENABLE_BIT]) |-> clock_output_pin_out != $past(clock_output_pin_ff))
    else $error("clock pin not toggling while enabled");
  baud_lock_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (reg_ff[BAUD_IDX][0] && !any_rst) |=> $stable(reg_ff[16]) && $stable(reg_ff[17]))
    else $error("baud divisor changed while generator enabled");
  indirect_sfr_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (ind_rd_in && ind_addr_in[7]) |=> ind_rdata_out == `ZERO_RST)
    else $error("indirect read reached the sfr space");
  code_far_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    code_far_s |-> code_done_s)
    else $error("off-chip code read not answered as erased");

endmodule

// File: sfr_bank_bench.sv
`include "sfr_bank_defines.svh"

module sfr_bank_bench;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // stimulus, observation and reference model state
  // ----------------------------------------------------------------
  logic        clk_sys_in      = 1'b0;
  logic        reset_n_in      = 1'b0;
  logic        code_rd_in      = 1'b0;
  logic [4:0]  src             = '0;  // ext, watchdog, software, break, brownout
  logic [5:0]  stb             = '0;  // dir wr/rd, ind wr/rd, bit wr/rd
  logic [5:0]  trim_factory_in = '0;
  logic [7:0]  xa              = '0;  // one address bus shared by the byte ports
  logic [7:0]  xd              = '0;
  logic [15:0] code_addr_in    = '0;
  wire  [7:0]  code_mem_data_in;
  logic [7:0]  dir_rdata_out, ind_rdata_out, code_rdata_out, a, b;
  logic [9:0]  code_mem_addr_out;
  logic [15:0] ca;
  logic [7:0]  cq[$];
  logic        bit_rdata_out, code_valid_out, clock_output_pin_out, rc_oscillator_select_out;
  logic        watchdog_service_first_out, watchdog_service_second_out;
  int          errors   = 0;
  int          compares = 0;
  int          sv1      = 0;
  int          sv2      = 0;
  int          nsv1     = 0;
  int          nsv2     = 0;
  int          m[256];
  int          mk[256];
  int          bb[3]    = '{'h88, 'h98, 'hd0};
  int          flag[5]  = '{0, 2, 1, 3, 5};
  // offset, reset value, implemented bits; fe stands for an unmapped place
  int          tab[27][3] = '{'{'h81, 'h07, 'hff}, '{'h88, 0, 'hf0}, '{'h89, 0, 'h33},
    '{'h8a, 0, 'hff}, '{'h8b, 0, 'hff}, '{'h8c, 0, 'hff}, '{'h8d, 0, 'hff}, '{'h96, 0, 'hff},
    '{'h98, 0, 'hff}, '{'h99, 0, 'hff}, '{'ha7, 'he5, 'he7}, '{'ha9, 0, 'hff}, '{'hb9, 0, 'hff},
    '{'hba, 0, 'hff}, '{'hc1, 'hff, 'hff}, '{'hc2, 0, 0}, '{'hc3, 0, 0}, '{'hd0, 0, 'hff},
    '{'hd1, 'h60, 'he3}, '{'hd2, 0, 'hff}, '{'hd3, 0, 'hff}, '{'hdf, 'h30, 'h3f},
    '{'hf6, 0, 'h3e}, '{'hec, 0, 'h01}, '{'hed, 0, 'hff}, '{'hee, 0, 'hff}, '{'hfe, 0, 0}};

  sfr_bank uut (
    .clk_sys_in                  (clk_sys_in),
    .reset_n_in                  (reset_n_in),
    .rst_external_in             (src[0]),
    .rst_watchdog_in             (src[1]),
    .rst_software_in             (src[2]),
    .rst_break_in                (src[3]),
    .rst_brownout_in             (src[4]),
    .trim_factory_in             (trim_factory_in),
    .dir_addr_in                 (xa),
    .dir_wr_in                   (stb[5]),
    .dir_rd_in                   (stb[4]),
    .dir_wdata_in                (xd),
    .ind_addr_in                 (xa),
    .ind_wr_in                   (stb[3]),
    .ind_rd_in                   (stb[2]),
    .ind_wdata_in                (xd),
    .bit_addr_in                 (xa),
    .bit_wr_in                   (stb[1]),
    .bit_rd_in                   (stb[0]),
    .bit_wdata_in                (xd[0]),
    .code_addr_in                (code_addr_in),
    .code_rd_in                  (code_rd_in),
    .code_mem_data_in            (code_mem_data_in),
    .dir_rdata_out               (dir_rdata_out),
    .ind_rdata_out               (ind_rdata_out),
    .bit_rdata_out               (bit_rdata_out),
    .code_mem_addr_out           (code_mem_addr_out),
    .code_rdata_out              (code_rdata_out),
    .code_valid_out              (code_valid_out),
    .clock_output_pin_out        (clock_output_pin_out),
    .rc_oscillator_select_out    (rc_oscillator_select_out),
    .watchdog_service_first_out  (watchdog_service_first_out),
    .watchdog_service_second_out (watchdog_service_second_out)
  );

  // code array stand-in: a pattern that differs per address within each 256-byte page, so a wrong fetch there shows
  function automatic logic [7:0] cm(logic [9:0] ad);
    return ad[7:0] ^ {6'h00, ad[9:8]} ^ 8'h3c;
  endfunction
  assign code_mem_data_in = cm(code_mem_addr_out);

  always #10 clk_sys_in = ~clk_sys_in;

  // count service pulses; a pulse longer than one cycle is counted once per cycle it lasts
  always @(negedge clk_sys_in) begin
    sv1 += watchdog_service_first_out;
    sv2 += watchdog_service_second_out;
  end

  // ----------------------------------------------------------------
  // compare, access and model tasks
  // ----------------------------------------------------------------
  task automatic chk(logic [15:0] s, logic [15:0] e);
    compares++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic complete_run();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // port 0 direct, 1 indirect, 2 bit; strobe held for exactly one sampling edge
  task automatic go(int p, bit w, logic [7:0] ad, logic [7:0] d);
    @(posedge clk_sys_in);
    xa  <= ad;
    xd  <= d;
    stb <= 6'h20 >> (2 * p + !w);
    @(posedge clk_sys_in);
    stb <= '0;
    @(posedge clk_sys_in);
    @(negedge clk_sys_in);
  endtask

  task automatic rd(int p, logic [7:0] ad, int e);
    go(p, 0, ad, 8'h00);
    chk(p == 0 ? dir_rdata_out : p == 1 ? ind_rdata_out : 8'(bit_rdata_out), 16'(e));
  endtask

  task automatic wr(logic [7:0] ad, logic [7:0] d);
    go(0, 1, ad, d);
    if (!(ad inside {8'hed, 8'hee}) || !m['hec][0]) m[ad] = d & mk[ad];
    nsv1 += ad == 8'hc2;
    nsv2 += ad == 8'hc3;
  endtask

  task automatic rdall();
    foreach (tab[i]) rd(0, 8'(tab[i][0]), m[tab[i][0]]);
  endtask

  task automatic por();
    foreach (tab[i]) m[tab[i][0]] = tab[i][1];
    for (int i = 0; i < `DATA_RAM_BYTES; i++) m[i] = 0;
    m['h96] = trim_factory_in;
  endtask

  // power-on-only registers keep their contents through the other sources, except the cause and timeout flags that those sources set
  task automatic sec(int s);
    foreach (tab[i]) begin
      if (!(tab[i][0] inside {'h96, 'ha7, 'hd1, 'hd2, 'hd3, 'hdf})) m[tab[i][0]] = tab[i][1];
    end
    m['hdf] |= 1 << flag[s];
    if (s == 1) m['ha7] |= 2;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h1425));
    foreach (tab[i]) mk[tab[i][0]] = tab[i][2];
    for (int i = 0; i < `DATA_RAM_BYTES; i++) mk[i] = 'hff;
    trim_factory_in <= 6'($urandom);
    repeat (10) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    por();
    rdall();
    // fill every register, then hit it with each secondary source in turn
    for (int s = 0; s <= 5; s++) begin
      foreach (tab[i]) wr(8'(tab[i][0]), 8'($urandom & tab[i][2]));
      rdall();
      if (s < 5) begin
        @(posedge clk_sys_in);
        src <= 5'(1 << s);
        @(posedge clk_sys_in);
        src <= '0;
        sec(s);
        rdall();
      end
    end
    wr(8'hec, 8'h01);
    wr(8'hed, 8'(~m['hed]));
    rd(0, 8'hed, m['hed]);
    wr(8'hec, 8'h00);
    wr(8'hee, 8'ha5);
    rd(0, 8'hee, 'ha5);
    foreach (bb[j]) begin
      for (int i = 0; i < 8; i++) begin
        b = 8'($urandom & (mk[bb[j]] >> i) & 1);
        go(2, 1, 8'(bb[j] + i), b);
        m[bb[j]] = ((m[bb[j]] & ~(1 << i)) | (b << i)) & mk[bb[j]];
        rd(2, 8'(bb[j] + i), (m[bb[j]] >> i) & 1);
      end
      rd(0, 8'(bb[j]), m[bb[j]]);
    end
    rd(2, 8'h90, 0);
    repeat (8) begin
      a = 8'($urandom % `DATA_RAM_BYTES);
      b = 8'($urandom);
      go(1, 1, a, b);
      m[a] = b;
      rd(0, a, b);
      wr(a ^ 8'h01, ~b);
      rd(1, a ^ 8'h01, m[a ^ 8'h01]);
    end
    go(1, 1, 8'h81, 8'h11);
    rd(0, 8'h81, m['h81]);
    rd(1, 8'h81, 0);
    wr(8'h96, 8'('h40 | (m['h96] & 'h3f)));
    b = 8'(clock_output_pin_out);
    @(negedge clk_sys_in);
    chk(clock_output_pin_out, !b);
    chk(rc_oscillator_select_out, 0);
    wr(8'h96, 8'('h80 | (m['h96] & 'h3f)));
    chk(clock_output_pin_out, 0);
    chk(rc_oscillator_select_out, 1);
    repeat (8) begin
      ca = 16'($urandom) >> (6 * ($urandom % 2));
      @(posedge clk_sys_in);
      code_addr_in <= ca;
      code_rd_in   <= 1'b1;
      @(posedge clk_sys_in);
      code_rd_in   <= 1'b0;
      cq.push_back(ca < `CODE_ONCHIP_BYTES ? cm(ca[9:0]) : 8'hff);
      @(negedge clk_sys_in);
      if (ca < `CODE_ONCHIP_BYTES) chk(code_mem_addr_out, ca[9:0]);
      @(negedge clk_sys_in);
      chk(code_valid_out, 1);
      chk(code_rdata_out, cq.pop_front());
      @(negedge clk_sys_in);
      chk(code_valid_out, 0);
    end
    chk(16'(sv1), 16'(nsv1));
    chk(16'(sv2), 16'(nsv2));
    // a second power-on must clear the timeout flag and reload a new trim value
    @(posedge clk_sys_in);
    reset_n_in      <= 1'b0;
    trim_factory_in <= 6'($urandom);
    repeat (3) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    por();
    rdall();
    complete_run();
  end

  // the run needs about 1900 cycles; this cuts a hang off well beyond that
  initial begin
    #400_000;
    errors++;
    complete_run();
  end
endmodule
